// ===== design/arinc_rx_pkg.sv
// constants, field positions and carriers for the dual serial receiver block
// assumes one system clock; the line state and bus pins arrive asynchronously
package arinc_rx_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ       = 200_000_000;
  localparam logic [2:0]  SAMPLE_LAST_FAST = 3'h0;
  localparam logic [2:0]  SAMPLE_LAST_SLOW = 3'h7;
  localparam int unsigned TX_DIV_FAST      = 10;
  localparam int unsigned TX_DIV_SLOW      = 80;
  localparam logic [6:0]  TX_HALF_FAST     = 7'(TX_DIV_FAST / 2 - 1);
  localparam logic [6:0]  TX_HALF_SLOW     = 7'(TX_DIV_SLOW / 2 - 1);
  localparam logic [3:0]  GAP_TMR_LAST     = 4'h9;
  localparam logic [1:0]  GAP_NULLS_LAST   = 2'h2;
  localparam logic [4:0]  BIT_SPACE_MIN    = 5'h08;
  localparam logic [4:0]  BIT_SPACE_MAX    = 5'h0C;
  localparam logic [5:0]  WORD_LAST_BIT    = 6'h1F;

  // ---------------------------------------------------------------
  // control word fields (bit 0 is bus line 5)
  // ---------------------------------------------------------------
  localparam int          CW_LOW_LINE  = 5;
  localparam int          CW_TOP_LINE  = 14;
  localparam int          CW_SELF_TEST = 0;
  localparam int          CW_RX1_FILT  = 1;
  localparam int          CW_RX1_B9    = 2;
  localparam int          CW_RX1_B10   = 3;
  localparam int          CW_RX2_FILT  = 4;
  localparam int          CW_RX2_B9    = 5;
  localparam int          CW_RX2_B10   = 6;
  localparam int          CW_TX_PAR    = 7;
  localparam int          CW_TX_DIV    = 8;
  localparam int          CW_RX_DIV    = 9;
  localparam logic [9:0]  CONTROL_RESET = 10'h001;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic hi;
    logic lo;
  } line_s;

  typedef struct packed {
    line_s [1:0] rx;
    logic        cws;
    logic        en1_n;
    logic        en2_n;
    logic        sel;
    logic        mr_n;
    logic [15:0] data;
  } pins_s;

  typedef enum logic [1:0] {RX_HUNT, RX_IDLE, RX_BITS, RX_GAP} rx_state_e;

  typedef struct packed {
    rx_state_e   st;
    logic [9:0]  ones;
    logic [9:0]  zeros;
    logic [9:0]  nulls;
    logic        trig_q;
    logic [4:0]  space;
    logic [5:0]  bit_cnt;
    logic [31:0] shift;
    logic [3:0]  gap_tmr;
    logic [1:0]  gap_cnt;
    logic [31:0] held;
    logic        ready_n;
    logic        b1_read;
    logic        b2_read;
    logic        rd_act;
    logic        sel_lat;
    logic        pend;
  } rx_chan_s;

  localparam rx_chan_s RX_CHAN_RESET = '{st: RX_HUNT, ready_n: 1'b1, default: '0};

  typedef struct packed {
    logic        chan;
    logic [31:0] word;
  } rx_word_s;

  typedef struct packed {
    pins_s          s1;
    pins_s          s2;
    logic           cws_q;
    logic           en1_q;
    logic           en2_q;
    logic [9:0]     control_word;
    logic [7:0]     master_cnt;
    logic [2:0]     sample_cnt;
    logic [6:0]     tx_cnt;
    logic           tx_clk;
    rx_chan_s [1:0] rx;
    rx_word_s       b0;
    rx_word_s       b1;
    logic           bv0;
    logic           bv1;
    logic [15:0]    dout;
    logic           oe;
    logic [1:0]     pulse;
  } top_s;

endpackage : arinc_rx_pkg

// ===== design/arinc429_dual_receiver_ctrl.sv
// two serial word receivers, the control word register and the parallel read port
// assumes line comparators give hi/lo levels; tx ones/zeros come from the local transmitter
`timescale 1ns/1ps
module arinc429_dual_receiver_ctrl
  import arinc_rx_pkg::*;
#(
  parameter int unsigned MASTER_CLK_HZ = 1_000_000
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        master_reset_n,
  input  wire line_s       rx1_line,
  input  wire line_s       rx2_line,
  input  wire logic        tx_ones_out,
  input  wire logic        tx_zeros_out,
  input  wire logic        control_word_strobe,
  input  wire logic        rx1_output_strobe_n,
  input  wire logic        rx2_output_strobe_n,
  input  wire logic        byte_choice,
  input  wire logic [15:0] parallel_data_lines_in,
  output logic      [15:0] parallel_data_lines_out,
  output logic             parallel_data_lines_oe,
  output logic             rx1_word_ready_n,
  output logic             rx2_word_ready_n,
  output logic      [1:0]  word_complete_pulse,
  output logic             tx_parity_polarity,
  output logic             tx_rate_divide_choice,
  output logic             tx_data_clk,
  output logic             rx_word_valid,
  output rx_word_s         rx_word,
  input  wire logic        rx_word_ready
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam logic [7:0] MASTER_LAST = 8'(SYS_CLK_HZ / MASTER_CLK_HZ - 1);

  function automatic logic [15:0] byte_one(input logic [31:0] w);
    byte_one = {w[12:8], w[30], w[29], w[31],
                w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
  endfunction : byte_one

  function automatic logic [15:0] byte_two(input logic [31:0] w);
    byte_two = w[28:13];
  endfunction : byte_two

  function automatic logic filter_pass(input logic [31:0] w, input logic en,
                                       input logic b9, input logic b10);
    filter_pass = !en || ((w[8] == b9) && (w[9] == b10));
  endfunction : filter_pass

  top_s        cur;
  top_s        next;
  pins_s       pins_now;
  line_s [1:0] seen;

  assign pins_now = {rx2_line, rx1_line, control_word_strobe, rx1_output_strobe_n,
                     rx2_output_strobe_n, byte_choice, master_reset_n, parallel_data_lines_in};

  // ---------------------------------------------------------------
  // receiver inputs, with self test loopback
  // ---------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_seen
    assign seen[gi] = cur.control_word[CW_SELF_TEST] ? cur.s2.rx[gi] :
                      line_s'({tx_ones_out, tx_zeros_out});
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        mtick;
    logic        stick;
    logic        pop;
    logic        one_t;
    logic        zero_t;
    logic        fire;
    logic        bad;
    logic        en_n;
    logic        en_q;
    logic        yield;
    logic [4:0]  sp;
    logic [31:0] full;
    rx_chan_s    c;
    rx_word_s    item;
    mtick  = 1'b0;
    stick  = 1'b0;
    pop    = 1'b0;
    one_t  = 1'b0;
    zero_t = 1'b0;
    fire   = 1'b0;
    bad    = 1'b0;
    en_n   = 1'b1;
    en_q   = 1'b1;
    yield  = 1'b0;
    sp     = '0;
    full   = '0;
    c      = cur.rx[0];
    item   = '0;
    next   = cur;
    next.s1    = pins_now;
    next.s2    = cur.s1;
    next.cws_q = cur.s2.cws;
    next.en1_q = cur.s2.en1_n;
    next.en2_q = cur.s2.en2_n;
    next.pulse = 2'h0;

    if (cur.s2.cws && !cur.cws_q) begin
      next.control_word = cur.s2.data[CW_TOP_LINE:CW_LOW_LINE];
    end

    // time base: master tick, sample tick, transmit data clock
    mtick = (cur.master_cnt == MASTER_LAST);
    next.master_cnt = mtick ? 8'h00 : 8'(cur.master_cnt + 8'h01);
    if (mtick) begin
      stick = (cur.sample_cnt == 3'h0);
      if (cur.sample_cnt >= (cur.control_word[CW_RX_DIV] ? SAMPLE_LAST_SLOW
                                                          : SAMPLE_LAST_FAST)) begin
        next.sample_cnt = 3'h0;
      end else begin
        next.sample_cnt = 3'(cur.sample_cnt + 3'h1);
      end
      if (cur.tx_cnt >= (cur.control_word[CW_TX_DIV] ? TX_HALF_SLOW : TX_HALF_FAST)) begin
        next.tx_cnt = 7'h00;
        next.tx_clk = !cur.tx_clk;
      end else begin
        next.tx_cnt = 7'(cur.tx_cnt + 7'h01);
      end
    end

    // read port
    next.oe = 1'b0;
    if (!cur.s2.en1_n) begin
      next.oe   = 1'b1;
      next.dout = cur.s2.sel ? byte_two(cur.rx[0].held) : byte_one(cur.rx[0].held);
    end else if (!cur.s2.en2_n) begin
      next.oe   = 1'b1;
      next.dout = cur.s2.sel ? byte_two(cur.rx[1].held) : byte_one(cur.rx[1].held);
    end

    for (int ch = 0; ch < 2; ch++) begin
      en_n  = (ch == 0) ? cur.s2.en1_n : cur.s2.en2_n;
      en_q  = (ch == 0) ? cur.en1_q : cur.en2_q;
      yield = (ch == 0) || cur.s2.en1_n;
      if (!en_n && yield) begin
        next.rx[ch].rd_act  = 1'b1;
        next.rx[ch].sel_lat = cur.s2.sel;
      end
      if (en_n && !en_q && cur.rx[ch].rd_act) begin
        next.rx[ch].rd_act = 1'b0;
        if (cur.rx[ch].sel_lat) begin
          next.rx[ch].b2_read = 1'b1;
        end else begin
          next.rx[ch].b1_read = 1'b1;
        end
      end
      if (next.rx[ch].b1_read && next.rx[ch].b2_read) begin
        next.rx[ch].ready_n = 1'b1;
        next.rx[ch].b1_read = 1'b0;
        next.rx[ch].b2_read = 1'b0;
      end
    end

    // two-entry word buffer toward the transmit side
    pop = cur.bv0 && rx_word_ready;
    if (pop) begin
      next.b0  = cur.b1;
      next.bv0 = cur.bv1;
      next.bv1 = 1'b0;
    end
    if (!cur.bv1 && (next.rx[0].pend || next.rx[1].pend)) begin
      item.chan = !next.rx[0].pend;
      item.word = next.rx[0].pend ? next.rx[0].held : next.rx[1].held;
      if (next.rx[0].pend) begin
        next.rx[0].pend = 1'b0;
      end else begin
        next.rx[1].pend = 1'b0;
      end
      if (!next.bv0) begin
        next.b0  = item;
        next.bv0 = 1'b1;
      end else begin
        next.b1  = item;
        next.bv1 = 1'b1;
      end
    end

    // samplers and word assembly
    for (int ch = 0; ch < 2; ch++) begin
      c = next.rx[ch];
      if (stick) begin
        bad     = seen[ch].hi && seen[ch].lo;
        c.ones  = {c.ones[8:0], seen[ch].hi && !seen[ch].lo};
        c.zeros = {c.zeros[8:0], seen[ch].lo && !seen[ch].hi};
        c.nulls = {c.nulls[8:0], !seen[ch].hi && !seen[ch].lo};
        one_t   = (&c.ones[9:7]) && (&c.nulls[2:0]);
        zero_t  = (&c.zeros[9:7]) && (&c.nulls[2:0]);
        fire    = (one_t || zero_t) && !c.trig_q;
        c.trig_q = one_t || zero_t;
        sp      = 5'(c.space + 5'h01);
        case (c.st)
          RX_HUNT: begin
            if ((&c.nulls[9:7]) && (&c.nulls[2:0])) begin
              c.st = RX_IDLE;
            end
          end
          RX_IDLE: begin
            if (bad) begin
              c.st = RX_HUNT;
            end else if (fire) begin
              c.shift    = {31'h0, one_t};
              c.bit_cnt  = 6'h01;
              c.space    = 5'h00;
              c.st       = RX_BITS;
            end
          end
          RX_BITS: begin
            c.space = sp;
            if (bad || (&c.ones[6:0]) || (&c.zeros[6:0])) begin
              c.st = RX_HUNT;
            end else if (fire) begin
              c.space = 5'h00;
              if (sp < BIT_SPACE_MIN || sp > BIT_SPACE_MAX) begin
                c.st = RX_HUNT;
              end else if (c.bit_cnt == WORD_LAST_BIT) begin
                full     = {one_t, c.shift[30:0]};
                full[31] = ~^full;
                next.pulse[ch] = 1'b1;
                if (filter_pass(full, cur.control_word[ch == 0 ? CW_RX1_FILT : CW_RX2_FILT],
                                cur.control_word[ch == 0 ? CW_RX1_B9 : CW_RX2_B9],
                                cur.control_word[ch == 0 ? CW_RX1_B10 : CW_RX2_B10])) begin
                  c.held    = full;
                  c.ready_n = 1'b0;
                  c.b1_read = 1'b0;
                  c.b2_read = 1'b0;
                  c.pend    = 1'b1;
                end
                c.gap_tmr = 4'h0;
                c.gap_cnt = 2'h0;
                c.st      = RX_GAP;
              end else begin
                c.shift[c.bit_cnt[4:0]] = one_t;
                c.bit_cnt = 6'(c.bit_cnt + 6'h01);
              end
            end else if (sp > BIT_SPACE_MAX) begin
              c.st = RX_HUNT;
            end
          end
          RX_GAP: begin
            if (c.gap_tmr == GAP_TMR_LAST) begin
              c.gap_tmr = 4'h0;
              if (c.nulls[0]) begin
                if (c.gap_cnt == GAP_NULLS_LAST) begin
                  c.st = RX_IDLE;
                end
                c.gap_cnt = 2'(c.gap_cnt + 2'h1);
              end
            end else begin
              c.gap_tmr = 4'(c.gap_tmr + 4'h1);
            end
          end
          default: begin
            c.st = RX_HUNT;
          end
        endcase
      end
      next.rx[ch] = c;
      if (!cur.s2.mr_n) begin
        next.rx[ch] = RX_CHAN_RESET;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur              <= '0;
      cur.s1.en1_n     <= 1'b1;
      cur.s1.en2_n     <= 1'b1;
      cur.s1.mr_n      <= 1'b1;
      cur.s2.en1_n     <= 1'b1;
      cur.s2.en2_n     <= 1'b1;
      cur.s2.mr_n      <= 1'b1;
      cur.en1_q        <= 1'b1;
      cur.en2_q        <= 1'b1;
      cur.control_word <= CONTROL_RESET;
      cur.rx[0]        <= RX_CHAN_RESET;
      cur.rx[1]        <= RX_CHAN_RESET;
    end else begin
      cur <= next;
    end
  end

  assign parallel_data_lines_out = cur.dout;
  assign parallel_data_lines_oe  = cur.oe;
  assign rx1_word_ready_n        = cur.rx[0].ready_n;
  assign rx2_word_ready_n        = cur.rx[1].ready_n;
  assign word_complete_pulse     = cur.pulse;
  assign tx_parity_polarity      = cur.control_word[CW_TX_PAR];
  assign tx_rate_divide_choice   = cur.control_word[CW_TX_DIV];
  assign tx_data_clk             = cur.tx_clk;
  assign rx_word_valid           = cur.bv0;
  assign rx_word                 = cur.b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_cw_capture: assert property (@(posedge sys_clk) disable iff (rst)
    (cur.s2.cws && !cur.cws_q) |=> cur.control_word == $past(cur.s2.data[CW_TOP_LINE:CW_LOW_LINE]))
    else $error("control word not captured on strobe edge");

  a_loopback_path: assert property (@(posedge sys_clk) disable iff (rst)
    !cur.control_word[CW_SELF_TEST] |-> (seen[0] == {tx_ones_out, tx_zeros_out})
                                        && (seen[1] == {tx_ones_out, tx_zeros_out}))
    else $error("self test does not route transmitter outputs");

  a_rx1_match: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(rx1_word_ready_n) && cur.control_word[CW_RX1_FILT]) |->
      cur.rx[0].held[8] == cur.control_word[CW_RX1_B9]
      && cur.rx[0].held[9] == cur.control_word[CW_RX1_B10])
    else $error("receiver 1 accepted a word failing its filter");

  a_rx2_match: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(rx2_word_ready_n) && cur.control_word[CW_RX2_FILT]) |->
      cur.rx[1].held[8] == cur.control_word[CW_RX2_B9]
      && cur.rx[1].held[9] == cur.control_word[CW_RX2_B10])
    else $error("receiver 2 accepted a word failing its filter");

  a_byte_one_map: assert property (@(posedge sys_clk) disable iff (rst)
    (!cur.s2.en1_n && !cur.s2.sel) |=>
      parallel_data_lines_oe && parallel_data_lines_out == byte_one($past(cur.rx[0].held)))
    else $error("receiver 1 byte 1 not on the bus");

  a_rx2_yield: assert property (@(posedge sys_clk) disable iff (rst)
    (!cur.s2.en2_n && cur.s2.en1_n && cur.s2.sel) |=>
      parallel_data_lines_out == byte_two($past(cur.rx[1].held)))
    else $error("receiver 2 byte 2 not on the bus");

  a_oe_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    parallel_data_lines_oe |-> $past(!cur.s2.en1_n || !cur.s2.en2_n))
    else $error("data lines driven without a strobe");

  a_ready_hold: assert property (@(posedge sys_clk) disable iff (rst || !cur.s2.mr_n)
    (!rx1_word_ready_n && !(cur.rx[0].rd_act && cur.s2.en1_n)) |=> !rx1_word_ready_n)
    else $error("ready flag rose before both bytes were read");

  a_pulse_single: assert property (@(posedge sys_clk) disable iff (rst)
    word_complete_pulse[0] |=> !word_complete_pulse[0] [*2])
    else $error("word complete pulse longer than one cycle");

  a_space_bound: assert property (@(posedge sys_clk) disable iff (rst)
    cur.rx[0].st == RX_BITS |-> cur.rx[0].space <= BIT_SPACE_MAX)
    else $error("bit spacing exceeded without rejection");

  a_gap_reenable: assert property (@(posedge sys_clk) disable iff (rst)
    (cur.rx[0].st == RX_GAP ##1 cur.rx[0].st == RX_IDLE) |->
      $past(cur.rx[0].gap_cnt) == GAP_NULLS_LAST)
    else $error("reception re-enabled before three gap nulls");

endmodule : arinc429_dual_receiver_ctrl

// ===== dv/arinc_tx_model.sv
// serial word source standing in for the remote line transmitter
// assumes ten receiver samples per bit time: HALF cycles of level, HALF of null
`timescale 1ns/1ps
module arinc_tx_model
  import arinc_rx_pkg::*;
#(
  parameter int HALF = 50
) (
  input  wire logic sys_clk,
  output line_s     line
);
  initial line = '0;
  // ---------------------------------------------------------------
  // word sender; glitch puts an out-of-range level in that bit's null
  // ---------------------------------------------------------------
  task automatic send(input logic [31:0] w, input int glitch);
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk);
      line <= w[i] ? 2'b10 : 2'b01;
      repeat (HALF) @(posedge sys_clk);
      line <= (i == glitch) ? 2'b11 : 2'b00;
      repeat (HALF - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    line <= '0;
    repeat (16 * HALF) @(posedge sys_clk);
  endtask : send
endmodule : arinc_tx_model

// ===== dv/testbench.sv
// self-checking bench for the dual serial receiver and its read port
// assumes a 200 MHz clock and a 20 MHz master tick, so one bit is 100 cycles
`timescale 1ns/1ps
module testbench;
  import arinc_rx_pkg::*;
  localparam logic [31:0] W1 = 32'h6A5C_C1A7;
  localparam logic [31:0] W2 = 32'h0F0F_02F3;
  localparam logic [31:0] W3 = 32'hA5A5_3C96;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        mr_n = 1'b1;
  logic        cws = 1'b0;
  logic        en1_n = 1'b1;
  logic        en2_n = 1'b1;
  logic        sel = 1'b0;
  logic        rxr = 1'b0;
  logic [15:0] din = 16'h0000;
  logic [15:0] dout;
  logic [15:0] b;
  logic        oe, rdy1_n, rdy2_n, par, txdiv, txclk, rxv;
  logic [1:0]  pulse;
  rx_word_s    rxw;
  line_s       line1, line2, line3;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          pcnt [2] = '{0, 0};

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (pulse[0] === 1'b1) pcnt[0]++;
    if (pulse[1] === 1'b1) pcnt[1]++;
  end

  arinc_tx_model i_arinc_tx_model_1 (.sys_clk(sys_clk), .line(line1));
  arinc_tx_model i_arinc_tx_model_2 (.sys_clk(sys_clk), .line(line2));
  arinc_tx_model i_arinc_tx_model_3 (.sys_clk(sys_clk), .line(line3));
  arinc429_dual_receiver_ctrl #(.MASTER_CLK_HZ(20_000_000)) i_arinc429_dual_receiver_ctrl (
    .sys_clk(sys_clk), .rst(rst), .master_reset_n(mr_n), .rx1_line(line1),
    .rx2_line(line2), .tx_ones_out(line3.hi), .tx_zeros_out(line3.lo),
    .control_word_strobe(cws), .rx1_output_strobe_n(en1_n),
    .rx2_output_strobe_n(en2_n), .byte_choice(sel), .parallel_data_lines_in(din),
    .parallel_data_lines_out(dout), .parallel_data_lines_oe(oe),
    .rx1_word_ready_n(rdy1_n), .rx2_word_ready_n(rdy2_n), .word_complete_pulse(pulse),
    .tx_parity_polarity(par), .tx_rate_divide_choice(txdiv), .tx_data_clk(txclk),
    .rx_word_valid(rxv), .rx_word(rxw), .rx_word_ready(rxr));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] held(input logic [31:0] w);
    return {~^w, w[30:0]};
  endfunction : held
  function automatic logic [15:0] byte1(input logic [31:0] e);
    return {e[12:8], e[30], e[29], e[31], {<<{e[7:0]}}};
  endfunction : byte1

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [1:0] en, input logic s, output logic [15:0] d);
    @(posedge sys_clk);
    sel <= s;
    en1_n <= ~en[0];
    en2_n <= ~en[1];
    repeat (6) @(posedge sys_clk);
    chk("bus enable on", 1, oe);
    d = dout;
    en1_n <= 1'b1;
    en2_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("bus enable off", 0, oe);
  endtask : rd

  task automatic cw_wr(input logic [9:0] v);
    @(posedge sys_clk);
    din <= {1'b0, v, 5'h00};
    repeat (4) @(posedge sys_clk);
    cws <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cws <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : cw_wr

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_control();
    realtime t0;
    cw_wr(10'h187);
    chk("tx parity", 1, par);
    chk("tx divide", 1, txdiv);
    @(posedge txclk);
    t0 = $realtime;
    @(posedge txclk);
    chk("tx clock period", TX_DIV_SLOW * 10, int'(($realtime - t0) / 5.0));
    $display("test control done");
  endtask : t_control

  task automatic t_rx1_accept();
    int n = pcnt[0];
    i_arinc_tx_model_1.send(W1, -1);
    chk("rx1 pulses", n + 1, pcnt[0]);
    chk("rx1 ready", 0, rdy1_n);
    rd(2'b01, 1'b0, b);
    chk("rx1 byte1", byte1(held(W1)), b);
    chk("rx1 ready half", 0, rdy1_n);
    rd(2'b01, 1'b1, b);
    chk("rx1 byte2", held(W1) >> 13 & 32'hFFFF, b);
    repeat (4) @(posedge sys_clk);
    chk("rx1 ready clear", 1, rdy1_n);
    $display("test rx1 accept done");
  endtask : t_rx1_accept

  task automatic t_rx1_filter_reject();
    int n = pcnt[0];
    i_arinc_tx_model_1.send(W2, -1);
    chk("filtered pulses", n + 1, pcnt[0]);
    chk("filtered ready", 1, rdy1_n);
    i_arinc_tx_model_1.send(W1, 5);
    chk("glitch pulses", n + 1, pcnt[0]);
    chk("glitch ready", 1, rdy1_n);
    $display("test rx1 filter and reject done");
  endtask : t_rx1_filter_reject

  task automatic t_self_test_slow();
    int n0 = pcnt[0];
    int n1 = pcnt[1];
    cw_wr(10'h186);
    i_arinc_tx_model_3.send(W1, -1);
    chk("loop pulses 1", n0 + 1, pcnt[0]);
    chk("loop pulses 2", n1 + 1, pcnt[1]);
    chk("loop ready 1", 0, rdy1_n);
    chk("loop ready 2", 0, rdy2_n);
    @(posedge sys_clk);
    mr_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    mr_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("reset ready 1", 1, rdy1_n);
    chk("reset ready 2", 1, rdy2_n);
    cw_wr(10'h387);
    repeat (1000) @(posedge sys_clk);
    i_arinc_tx_model_1.send(W1, -1);
    chk("slow rate pulses", n0 + 1, pcnt[0]);
    chk("slow rate ready", 1, rdy1_n);
    $display("test self test, reset and slow rate done");
  endtask : t_self_test_slow

  task automatic t_rx2_buffer();
    i_arinc_tx_model_2.send(W3, -1);
    chk("rx2 ready", 0, rdy2_n);
    rd(2'b10, 1'b1, b);
    chk("rx2 byte2", held(W3) >> 13 & 32'hFFFF, b);
    rd(2'b10, 1'b0, b);
    chk("rx2 byte1", byte1(held(W3)), b);
    repeat (4) @(posedge sys_clk);
    chk("rx2 ready clear", 1, rdy2_n);
    rd(2'b11, 1'b1, b);
    chk("both strobes", held(W1) >> 13 & 32'hFFFF, b);
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      chk("buffer valid", 1, rxv);
      chk("buffer word", k ? held(W3) : held(W1), rxw.word);
      chk("buffer chan", k, rxw.chan);
      @(posedge sys_clk);
      rxr <= 1'b1;
      @(posedge sys_clk);
      rxr <= 1'b0;
    end
    @(negedge sys_clk);
    chk("buffer empty", 0, rxv);
    $display("test rx2 and buffer done");
  endtask : t_rx2_buffer

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // receivers leave the hunt state once the three newest and three oldest of the last ten samples are null
    repeat (200) @(posedge sys_clk);
    t_control();
    t_rx1_accept();
    t_rx1_filter_reject();
    t_rx2_buffer();
    t_self_test_slow();
    end_sim();
  end
endmodule : testbench
